/* pqc_pkg.sv */
// Constants for the performance event qualification and fixed counter block.
// Assumes a single core clock domain and an internal register select port.
package pqc_pkg;

  // Register select codes on the internal register port
  localparam logic [3:0] PQC_SEL_EVSEL_BASE = 4'h0;
  localparam logic [3:0] PQC_SEL_GPCTR_BASE = 4'h4;
  localparam logic [3:0] PQC_SEL_FIXCTR_BASE = 4'h8;
  localparam logic [3:0] PQC_SEL_FIXCTRL = 4'hC;

  // Counter geometry
  localparam int PQC_CTR_WIDTH = 40;
  localparam int PQC_NUM_FIXED = 3;
  localparam int PQC_NUM_GP = 2;
  localparam int PQC_FIX_FIELD_W = 4;

  // Event select fields
  localparam int PQC_EVCODE_LSB = 0;
  localparam int PQC_UMASK_LSB = 8;
  localparam int PQC_EVSEL_USR_BIT = 16;
  localparam int PQC_EVSEL_OS_BIT = 17;
  localparam int PQC_EVSEL_INT_BIT = 20;
  localparam int PQC_EVSEL_EN_BIT = 22;
  localparam logic [63:0] PQC_EVSEL_RESET = 64'h0000_0000_0000_0000;

  // Qualifier mask sub-fields, positions within the 8-bit mask
  localparam int PQC_Q_CORE_HI = 7;
  localparam int PQC_Q_CORE_LO = 6;
  localparam int PQC_Q_AGENT = 5;
  localparam int PQC_Q_PF_HI = 5;
  localparam int PQC_Q_PF_LO = 4;
  localparam logic [1:0] PQC_CORE_ALL = 2'h3;
  localparam logic [1:0] PQC_CORE_SELF = 2'h1;
  localparam logic [1:0] PQC_PF_ALL = 2'h3;
  localparam logic [1:0] PQC_PF_ONLY = 2'h1;
  localparam logic [1:0] PQC_PF_EXCL = 2'h0;

  // Which state-like sub-field an event uses
  typedef enum logic [1:0] {
    PQC_KIND_NONE  = 2'h0,
    PQC_KIND_MESI  = 2'h1,
    PQC_KIND_SRESP = 2'h2,
    PQC_KIND_STYPE = 2'h3
  } pqc_kind_e;

  // Fixed counter control field bits
  localparam int PQC_FIX_RING0_BIT = 0;
  localparam int PQC_FIX_RINGN_BIT = 1;
  localparam int PQC_FIX_IRQ_BIT = 3;
  localparam logic [11:0] PQC_FIXCTRL_RESET = 12'h000;
  localparam logic [3:0] PQC_FIX_FIELD_MASK = 4'hB;

endpackage

/* pqc_qualify.sv */
// Qualifier mask decode for one general-purpose counter's event stream.
// Assumes event attributes arrive on the core clock, already aligned to the pulse.
`timescale 1ns/10ps
module pqc_qualify (
  // Qualifier mask from the event select register
  input  wire logic [7:0]            umask_in,
  // Which sub-fields the selected event supports
  input  wire logic                  has_core_in,
  input  wire logic                  has_agent_in,
  input  wire logic                  has_prefetch_in,
  input  wire logic                  core_only_in,
  input  wire pqc_pkg::pqc_kind_e    kind_in,
  // Event occurrence and its attributes
  input  wire logic                  ev_pulse_in,
  input  wire logic                  ev_own_core_in,
  input  wire logic                  ev_own_agent_in,
  input  wire logic                  ev_hw_prefetch_in,
  input  wire logic [3:0]            ev_line_state_in,
  input  wire logic [2:0]            ev_snoop_resp_in,
  input  wire logic [1:0]            ev_snoop_type_in,
  // Qualified event
  output logic                       hit_out
);
  import pqc_pkg::*;

  logic core_ok;
  logic agent_ok;
  logic pf_ok;
  logic state_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Topology qualifiers
  always_comb begin
    core_ok = 1'b1;
    // Core-only conditions ignore topology encodings
    if (has_core_in && !core_only_in) begin
      unique case (umask_in[PQC_Q_CORE_HI:PQC_Q_CORE_LO])
        PQC_CORE_ALL:  core_ok = 1'b1;
        PQC_CORE_SELF: core_ok = ev_own_core_in;
        default:       core_ok = 1'b0;
      endcase
    end
  end

  always_comb begin
    agent_ok = 1'b1;
    if (has_agent_in && !core_only_in) begin
      agent_ok = umask_in[PQC_Q_AGENT] | ev_own_agent_in;
    end
  end

  // Agent and prefetch share bit 13; agent use wins so both never apply
  always_comb begin
    pf_ok = 1'b1;
    if (has_prefetch_in && !has_agent_in) begin
      unique case (umask_in[PQC_Q_PF_HI:PQC_Q_PF_LO])
        PQC_PF_ALL:  pf_ok = 1'b1;
        PQC_PF_ONLY: pf_ok = ev_hw_prefetch_in;
        PQC_PF_EXCL: pf_ok = !ev_hw_prefetch_in;
        default:     pf_ok = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State-like qualifiers, one kind per event
  always_comb begin
    unique case (kind_in)
      PQC_KIND_MESI:  state_ok = |(umask_in[3:0] & ev_line_state_in);
      PQC_KIND_SRESP: state_ok = |({umask_in[3], umask_in[1:0]} & ev_snoop_resp_in);
      PQC_KIND_STYPE: state_ok = |(umask_in[1:0] & ev_snoop_type_in);
      default:        state_ok = 1'b1;
    endcase
  end

  assign hit_out = ev_pulse_in & core_ok & agent_ok & pf_ok & state_ok;

endmodule // pqc_qualify

/* pqc_counters.sv */
// Function
// - Bits 15:8 of event select are qualifier
// - Core field: 11 all cores, 01 self
// - Agent bit: 0 this agent, 1 all
// - Prefetch field: 11 all, 01 only, 00 exclude
// - Agent and prefetch qualification never combined
// - Events may use none or allowed pairs
// - Core-only events ignore core and agent fields
// - Bits 11:8 select modified, exclusive, shared, invalid
// - No state bit set means no count
// - Snoop response: modified-hit, hit, clean; 10 reserved
// - Snoop type: invalidate bit 9, share bit 8
// - At most one state-like sub-field per event
// - Counters undefined after reset; software loads them
// - Three fixed 40-bit counters; upper bits zero
// - Fixed counters ignore event select and mask
// - One 4-bit control field per fixed counter
// - Bit 0 enables counting at ring zero
// - Bit 1 enables counting above ring zero
// - 00 stops counting; 11 counts any ring
// - Fourth bit raises interrupt on overflow
// - Global enable ANDed with privilege enables
//
// Top of the event qualification and fixed counter block.
// Assumes event sources, ring level and global enables share the core clock.
`timescale 1ns/10ps
module pqc_counters #(
  parameter int NUM_GP    = pqc_pkg::PQC_NUM_GP,
  parameter int CTR_WIDTH = pqc_pkg::PQC_CTR_WIDTH
) (
  // Clock and reset
  input  wire logic                        clock_in,
  input  wire logic                        rstn_in,
  // Register port
  input  wire logic [3:0]                  reg_sel_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  input  wire logic [63:0]                 reg_wdata_in,
  output logic [63:0]                      reg_rdata_out,
  output logic                             reg_rvalid_out,
  // Processor state
  input  wire logic                        ring0_in,
  input  wire logic [NUM_GP-1:0]           gp_global_en_in,
  input  wire logic [2:0]                  fix_global_en_in,
  // Event code routing back to the core
  output logic [NUM_GP*8-1:0]              gp_event_code_out,
  // General-purpose event streams and attributes
  input  wire logic [NUM_GP-1:0]           gp_ev_pulse_in,
  input  wire logic [NUM_GP-1:0]           gp_has_core_in,
  input  wire logic [NUM_GP-1:0]           gp_has_agent_in,
  input  wire logic [NUM_GP-1:0]           gp_has_prefetch_in,
  input  wire logic [NUM_GP-1:0]           gp_core_only_in,
  input  wire logic [NUM_GP*2-1:0]         gp_kind_in,
  input  wire logic [NUM_GP-1:0]           gp_own_core_in,
  input  wire logic [NUM_GP-1:0]           gp_own_agent_in,
  input  wire logic [NUM_GP-1:0]           gp_hw_prefetch_in,
  input  wire logic [NUM_GP*4-1:0]         gp_line_state_in,
  input  wire logic [NUM_GP*3-1:0]         gp_snoop_resp_in,
  input  wire logic [NUM_GP*2-1:0]         gp_snoop_type_in,
  // Fixed-function event streams
  input  wire logic [2:0]                  fix_ev_pulse_in,
  // Overflow reporting toward the interrupt controller
  output logic [NUM_GP-1:0]                gp_overflow_out,
  output logic [2:0]                       fix_overflow_out,
  output logic                             overflow_irq_out
);
  import pqc_pkg::*;

  localparam int NFIX = PQC_NUM_FIXED;
  localparam int FW = PQC_FIX_FIELD_W;

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers

  // Privilege gate used by both counter kinds
  function automatic logic priv_ok(input logic ring0_en, input logic ringn_en,
                                   input logic at_ring0, input logic global_en);
    priv_ok = global_en & ((ring0_en & at_ring0) | (ringn_en & !at_ring0));
  endfunction

  // Counter register write data: only the low counter bits are kept
  function automatic logic [CTR_WIDTH-1:0] ctr_wdata(input logic [63:0] d);
    ctr_wdata = d[CTR_WIDTH-1:0];
  endfunction

  // Zero-extend a counter for read-back
  function automatic logic [63:0] ctr_rdata(input logic [CTR_WIDTH-1:0] c);
    ctr_rdata = {{(64 - CTR_WIDTH){1'b0}}, c};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [63:0]          evsel [NUM_GP];
  logic [CTR_WIDTH-1:0] gp_ctr [NUM_GP];
  logic [CTR_WIDTH-1:0] fix_ctr [NFIX];
  logic [11:0]          fix_ctrl;

  logic [NUM_GP-1:0]    gp_hit;
  logic [NUM_GP-1:0]    gp_count;
  logic [NUM_GP-1:0]    gp_wrap;
  logic [NUM_GP-1:0]    gp_wr;
  logic [NFIX-1:0]      fix_count;
  logic [NFIX-1:0]      fix_wrap;
  logic [NFIX-1:0]      fix_wr;
  logic                 next_irq;
  logic [63:0]          next_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  always_comb begin
    for (int i = 0; i < NUM_GP; i++) begin
      gp_wr[i] = reg_wr_in && (reg_sel_in == 4'(PQC_SEL_GPCTR_BASE + 4'(i)));
    end
    for (int i = 0; i < NFIX; i++) begin
      fix_wr[i] = reg_wr_in && (reg_sel_in == 4'(PQC_SEL_FIXCTR_BASE + 4'(i)));
    end
  end

  // Event select registers
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < NUM_GP; i++) begin
        evsel[i] <= PQC_EVSEL_RESET;
      end
    end else if (reg_wr_in) begin
      for (int i = 0; i < NUM_GP; i++) begin
        if (reg_sel_in == 4'(PQC_SEL_EVSEL_BASE + 4'(i))) begin
          evsel[i] <= reg_wdata_in;
        end
      end
    end
  end

  // Fixed counter control: bit 2 of each field is not implemented
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fix_ctrl <= PQC_FIXCTRL_RESET;
    end else if (reg_wr_in && reg_sel_in == PQC_SEL_FIXCTRL) begin
      for (int i = 0; i < NFIX; i++) begin
        fix_ctrl[i*FW +: FW] <= reg_wdata_in[i*FW +: FW] & PQC_FIX_FIELD_MASK;
      end
    end
  end

  // Event codes handed to the core so it routes the chosen event here
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gp_event_code_out <= '0;
    end else begin
      for (int i = 0; i < NUM_GP; i++) begin
        gp_event_code_out[i*8 +: 8] <= evsel[i][PQC_EVCODE_LSB +: 8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Qualification of general-purpose events

  for (genvar g = 0; g < NUM_GP; g++) begin : g_qual
    pqc_qualify u_qualify (
      .umask_in          (evsel[g][PQC_UMASK_LSB +: 8]),
      .has_core_in       (gp_has_core_in[g]),
      .has_agent_in      (gp_has_agent_in[g]),
      .has_prefetch_in   (gp_has_prefetch_in[g]),
      .core_only_in      (gp_core_only_in[g]),
      .kind_in           (pqc_kind_e'(gp_kind_in[g*2 +: 2])),
      .ev_pulse_in       (gp_ev_pulse_in[g]),
      .ev_own_core_in    (gp_own_core_in[g]),
      .ev_own_agent_in   (gp_own_agent_in[g]),
      .ev_hw_prefetch_in (gp_hw_prefetch_in[g]),
      .ev_line_state_in  (gp_line_state_in[g*4 +: 4]),
      .ev_snoop_resp_in  (gp_snoop_resp_in[g*3 +: 3]),
      .ev_snoop_type_in  (gp_snoop_type_in[g*2 +: 2]),
      .hit_out           (gp_hit[g])
    );
  end

  always_comb begin
    for (int i = 0; i < NUM_GP; i++) begin
      gp_count[i] = gp_hit[i] && evsel[i][PQC_EVSEL_EN_BIT] &&
                    priv_ok(evsel[i][PQC_EVSEL_OS_BIT], evsel[i][PQC_EVSEL_USR_BIT],
                            ring0_in, gp_global_en_in[i]);
      gp_wrap[i] = gp_count[i] && (&gp_ctr[i]);
    end
  end

  // Counters carry no reset: software loads them before enabling
  always_ff @(posedge clock_in) begin
    for (int i = 0; i < NUM_GP; i++) begin
      if (gp_wr[i]) begin
        gp_ctr[i] <= ctr_wdata(reg_wdata_in);
      end else if (gp_count[i]) begin
        gp_ctr[i] <= gp_ctr[i] + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fixed-function counters, gated by their control fields and global enables, not event select

  always_comb begin
    for (int i = 0; i < NFIX; i++) begin
      fix_count[i] = fix_ev_pulse_in[i] &&
                     priv_ok(fix_ctrl[i*FW + PQC_FIX_RING0_BIT],
                             fix_ctrl[i*FW + PQC_FIX_RINGN_BIT],
                             ring0_in, fix_global_en_in[i]);
      fix_wrap[i] = fix_count[i] && (&fix_ctr[i]);
    end
  end

  // Same no-reset policy as the general counters
  always_ff @(posedge clock_in) begin
    for (int i = 0; i < NFIX; i++) begin
      if (fix_wr[i]) begin
        fix_ctr[i] <= ctr_wdata(reg_wdata_in);
      end else if (fix_count[i]) begin
        fix_ctr[i] <= fix_ctr[i] + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overflow reporting

  // A write in the wrap cycle wins, so no stale overflow is reported
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gp_overflow_out  <= '0;
      fix_overflow_out <= '0;
    end else begin
      gp_overflow_out  <= gp_wrap & ~gp_wr;
      fix_overflow_out <= fix_wrap & ~fix_wr;
    end
  end

  always_comb begin
    next_irq = 1'b0;
    for (int i = 0; i < NFIX; i++) begin
      if (fix_wrap[i] && !fix_wr[i] && fix_ctrl[i*FW + PQC_FIX_IRQ_BIT]) begin
        next_irq = 1'b1;
      end
    end
    for (int i = 0; i < NUM_GP; i++) begin
      if (gp_wrap[i] && !gp_wr[i] && evsel[i][PQC_EVSEL_INT_BIT]) begin
        next_irq = 1'b1;
      end
    end
  end

  // One-cycle request to the local interrupt controller
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      overflow_irq_out <= 1'b0;
    end else begin
      overflow_irq_out <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-back, one cycle after the read strobe; unmapped selects read zero

  always_comb begin
    next_rdata = 64'h0000_0000_0000_0000;
    for (int i = 0; i < NUM_GP; i++) begin
      if (reg_sel_in == 4'(PQC_SEL_EVSEL_BASE + 4'(i))) begin
        next_rdata = evsel[i];
      end
      if (reg_sel_in == 4'(PQC_SEL_GPCTR_BASE + 4'(i))) begin
        next_rdata = ctr_rdata(gp_ctr[i]);
      end
    end
    for (int i = 0; i < NFIX; i++) begin
      if (reg_sel_in == 4'(PQC_SEL_FIXCTR_BASE + 4'(i))) begin
        next_rdata = ctr_rdata(fix_ctr[i]);
      end
    end
    if (reg_sel_in == PQC_SEL_FIXCTRL) begin
      next_rdata = {52'h0_0000_0000_0000, fix_ctrl};
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out  <= 64'h0000_0000_0000_0000;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= next_rdata;
      end
    end
  end

endmodule // pqc_counters

/* pqc_checker.sv */
// Port-level assertions for the event qualification and fixed counter block.
// Assumes one core clock, async active-low reset, bound to the top module.
`timescale 1ns/10ps
module pqc_checker #(
  parameter int NUM_GP    = pqc_pkg::PQC_NUM_GP,
  parameter int CTR_WIDTH = pqc_pkg::PQC_CTR_WIDTH
) (
  // Clock and reset
  input wire logic              clock_in,
  input wire logic              rstn_in,
  // Register port
  input wire logic [3:0]        reg_sel_in,
  input wire logic              reg_wr_in,
  input wire logic              reg_rd_in,
  input wire logic [63:0]       reg_wdata_in,
  input wire logic [63:0]       reg_rdata_out,
  input wire logic              reg_rvalid_out,
  // Counting and overflow
  input wire logic              ring0_in,
  input wire logic [2:0]        fix_global_en_in,
  input wire logic [2:0]        fix_ev_pulse_in,
  input wire logic [NUM_GP-1:0] gp_overflow_out,
  input wire logic [2:0]        fix_overflow_out,
  input wire logic              overflow_irq_out
);
  //////////////////////////////////////////////////////////////////////////////
  // Shadow of the fixed control register, rebuilt from observed writes
  logic [11:0] ctl;
  logic [2:0]  run_en;
  logic [2:0]  irq_en;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctl <= 12'h000;
    end else if (reg_wr_in && reg_sel_in == 4'hC) begin
      ctl <= reg_wdata_in[11:0];
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      run_en[i] = fix_global_en_in[i] & (ring0_in ? ctl[4*i] : ctl[4*i+1]);
      irq_en[i] = ctl[4*i+3];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  read_answer_a: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered next cycle");
  answer_cause_a: assert property (reg_rvalid_out |-> $past(reg_rd_in))
    else $error("read answer without a read");
  ctrl_read_a: assert property (reg_rd_in && reg_sel_in == 4'hC |=>
    reg_rdata_out == {52'h0, $past(ctl) & 12'hBBB}) else $error("fixed control readback wrong");
  ctr_width_a: assert property (reg_rd_in && reg_sel_in inside {[4'h8:4'hA]} |=>
    (reg_rdata_out >> CTR_WIDTH) == 64'h0) else $error("counter bits above width set");
  unmapped_zero_a: assert property (reg_rd_in && reg_sel_in > 4'hC |=> reg_rdata_out == 64'h0)
    else $error("unmapped read not zero");
  fix_ovf_cause_a: assert property (
    (fix_overflow_out & ~$past(fix_ev_pulse_in & run_en)) == 3'h0)
    else $error("fixed overflow without an enabled event");
  ovf_single_a: assert property ((fix_overflow_out & $past(fix_overflow_out)) == 3'h0)
    else $error("fixed overflow held longer than one cycle");
  irq_request_a: assert property (|(fix_overflow_out & $past(irq_en)) |-> overflow_irq_out)
    else $error("overflow interrupt missing");
  irq_cause_a: assert property (overflow_irq_out |->
    |(fix_overflow_out & $past(irq_en)) || |gp_overflow_out) else $error("spurious interrupt");

  cover property (|fix_overflow_out);
  cover property (overflow_irq_out);
  cover property (reg_rvalid_out && reg_rdata_out != 64'h0);
endmodule // pqc_checker

bind pqc_counters pqc_checker #(.NUM_GP(NUM_GP), .CTR_WIDTH(CTR_WIDTH)) i_pqc_checker (
  .clock_in, .rstn_in, .reg_sel_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out,
  .reg_rvalid_out, .ring0_in, .fix_global_en_in, .fix_ev_pulse_in, .gp_overflow_out,
  .fix_overflow_out, .overflow_irq_out
);

/* pqc_event_source.sv */
// Model of the core event sources and the interrupt controller input.
// Assumes the bench calls burst from its main sequence, off the rising edge.
`timescale 1ns/10ps
module pqc_event_source (
  // Clock and reset
  input wire logic  clock_in,
  input wire logic  rstn_in,
  // Interrupt from the counter block
  input wire logic  overflow_irq_in,
  // Event pulses toward the counter block
  output logic [2:0] fix_ev_pulse_out,
  output logic [1:0] gp_ev_pulse_out
);
  int irq_seen;

  initial begin
    fix_ev_pulse_out = 3'h0;
    gp_ev_pulse_out = 2'h0;
    irq_seen = 0;
  end

  // Sampled mid-cycle, away from the edge that launches the registered pulse
  always @(negedge clock_in) begin
    if (rstn_in && overflow_irq_in) begin
      irq_seen++;
    end
  end

  // One-cycle pulses, gap plus one idle cycles between them for a slow source
  task automatic burst(input logic [4:0] m, input int n, input int gap);
    repeat (n) begin
      @(negedge clock_in);
      {gp_ev_pulse_out, fix_ev_pulse_out} = m;
      @(negedge clock_in);
      {gp_ev_pulse_out, fix_ev_pulse_out} = 5'h00;
      repeat (gap) @(negedge clock_in);
    end
  endtask
endmodule // pqc_event_source

/* perf_event_qualify_counters_tb.sv */
// Self-checking bench for the event qualification and fixed counter block.
// Assumes the checker is bound to the top module and the event source model.
`timescale 1ns/10ps
module perf_event_qualify_counters_tb;
  import pqc_pkg::*;
  logic        clock_in, rstn_in, wr, rd, ring0, rvalid, irq;
  logic [3:0]  sel, kind, ty, f, g;
  logic [63:0] wdata, rdata;
  logic [1:0]  gen, hc, ha, hp, co, oc, oa, hw, gpul, govf, govf_seen;
  logic [2:0]  fen, fpul, fovf, fovf_seen;
  logic [7:0]  ls;
  logic [5:0]  rs;
  logic [15:0] code;
  int          n_fail, checked, n_irq;

  pqc_counters #(.NUM_GP(2), .CTR_WIDTH(PQC_CTR_WIDTH)) i_pqc_counters (
    .clock_in(clock_in), .rstn_in(rstn_in), .reg_sel_in(sel), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .ring0_in(ring0), .gp_global_en_in(gen), .fix_global_en_in(fen),
    .gp_event_code_out(code), .gp_ev_pulse_in(gpul), .gp_has_core_in(hc),
    .gp_has_agent_in(ha), .gp_has_prefetch_in(hp), .gp_core_only_in(co),
    .gp_kind_in(kind), .gp_own_core_in(oc), .gp_own_agent_in(oa), .gp_hw_prefetch_in(hw),
    .gp_line_state_in(ls), .gp_snoop_resp_in(rs), .gp_snoop_type_in(ty),
    .fix_ev_pulse_in(fpul), .gp_overflow_out(govf), .fix_overflow_out(fovf),
    .overflow_irq_out(irq));
  pqc_event_source i_pqc_event_source (.clock_in(clock_in), .rstn_in(rstn_in),
    .overflow_irq_in(irq), .fix_ev_pulse_out(fpul), .gp_ev_pulse_out(gpul));

  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  // Overflow pulses stand one cycle; gather them mid-cycle for later checks
  always @(negedge clock_in) begin
    fovf_seen = fovf_seen | fovf;
    govf_seen = govf_seen | govf;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
    checked++;
    if (got !== ex) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic wreg(input logic [3:0] s, input logic [63:0] d);
    @(negedge clock_in);
    sel = s;
    wdata = d;
    wr = 1'b1;
    @(negedge clock_in);
    wr = 1'b0;
  endtask

  // Answer comes one cycle after the read edge; the wait is bounded
  task automatic rreg(input logic [3:0] s, input logic [63:0] ex, input string nm);
    @(negedge clock_in);
    sel = s;
    rd = 1'b1;
    @(negedge clock_in);
    rd = 1'b0;
    for (int k = 0; k < 4 && rvalid !== 1'b1; k++) @(negedge clock_in);
    if (rvalid !== 1'b1) begin
      n_fail++;
      summarize();
    end else begin
      chk(nm, ex, rdata);
    end
  endtask

  function automatic logic [63:0] expc(input logic [3:0] c);
    return {60'h0, (c[0] ? 4'h3 : 4'h0) + (c[1] ? 4'h2 : 4'h0)};
  endfunction

  // One qualified event on counter 0; fl = core, agent, prefetch, core-only support
  task automatic q(input logic [7:0] um, input logic [1:0] kd, input logic [3:0] fl,
                   input logic [2:0] at, input logic [3:0] st, input logic [2:0] rp,
                   input logic [1:0] tp, input logic ex);
    wreg(PQC_SEL_GPCTR_BASE, 64'h0);
    wreg(PQC_SEL_EVSEL_BASE, {40'h0, 8'h43, um, 8'h3C});
    kind[1:0] = kd;
    {hc[0], ha[0], hp[0], co[0]} = fl;
    {oc[0], oa[0], hw[0]} = at;
    ls[3:0] = st;
    rs[2:0] = rp;
    ty[1:0] = tp;
    i_pqc_event_source.burst(5'h08, 1, 1);
    chk("event code", 64'h3C, {56'h0, code[7:0]});
    rreg(PQC_SEL_GPCTR_BASE, {63'h0, ex}, "gp counter");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {wr, rd, sel, wdata, hc, ha, hp, co, oc, oa, hw, kind, ls, rs, ty} = '0;
    ring0 = 1'b1;
    gen = 2'h3;
    fen = 3'h5;
    n_fail = 0;
    checked = 0;
    rstn_in = 1'b0;
    repeat (10) @(posedge clock_in);
    @(negedge clock_in);
    rstn_in = 1'b1;
    rreg(PQC_SEL_FIXCTRL, 64'h0, "fixed ctrl reset");
    // Every enable code, counter 1 held off by its global enable
    for (int e = 0; e < 4; e++) begin
      f = 4'(e);
      g = 4'(3 - e);
      for (int i = 0; i < 3; i++) wreg(PQC_SEL_FIXCTR_BASE + 4'(i), 64'h0);
      wreg(PQC_SEL_FIXCTRL, {52'h0, g, 4'h3, f});
      ring0 = 1'b1;
      i_pqc_event_source.burst(5'h07, 3, 0);
      ring0 = 1'b0;
      i_pqc_event_source.burst(5'h07, 2, 1);
      ring0 = 1'b1;
      rreg(PQC_SEL_FIXCTR_BASE, expc(f), "fixed counter 0");
      rreg(PQC_SEL_FIXCTR_BASE + 4'h1, 64'h0, "fixed counter 1");
      rreg(PQC_SEL_FIXCTR_BASE + 4'h2, expc(g), "fixed counter 2");
    end
    // Wrap with and without the interrupt bit
    fen = 3'h7;
    n_irq = i_pqc_event_source.irq_seen;
    wreg(PQC_SEL_FIXCTRL, 64'h03B);
    wreg(PQC_SEL_FIXCTR_BASE, 64'hFF_FFFF_FFFF);
    wreg(PQC_SEL_FIXCTR_BASE + 4'h1, 64'hFF_FFFF_FFFF);
    {fovf_seen, govf_seen} = '0;
    i_pqc_event_source.burst(5'h03, 1, 3);
    chk("irq count", 64'(n_irq + 1), 64'(i_pqc_event_source.irq_seen));
    chk("fixed overflow", 64'h3, {61'h0, fovf_seen});
    rreg(PQC_SEL_FIXCTR_BASE, 64'h0, "wrapped counter");
    wreg(PQC_SEL_FIXCTRL, 64'h033);
    wreg(PQC_SEL_FIXCTR_BASE, 64'hFF_FFFF_FFFF);
    {fovf_seen, govf_seen} = '0;
    i_pqc_event_source.burst(5'h01, 1, 3);
    chk("irq masked", 64'(n_irq + 1), 64'(i_pqc_event_source.irq_seen));
    chk("masked overflow", 64'h1, {61'h0, fovf_seen});
    // Reserved bits and unmapped place
    wreg(PQC_SEL_FIXCTRL, '1);
    rreg(PQC_SEL_FIXCTRL, 64'hBBB, "fixed ctrl mask");
    wreg(PQC_SEL_FIXCTR_BASE + 4'h2, 64'hFF_FFFF_FFFF);
    rreg(PQC_SEL_FIXCTR_BASE + 4'h2, 64'hFF_FFFF_FFFF, "counter width");
    wreg(4'hF, '1);
    rreg(4'hF, 64'h0, "unmapped");
    // Qualifier decode on general counter 0
    q(8'hC0, 2'h0, 4'h8, 3'h0, 4'h0, 3'h0, 2'h0, 1'b1);
    q(8'h40, 2'h0, 4'h8, 3'h0, 4'h0, 3'h0, 2'h0, 1'b0);
    q(8'h80, 2'h0, 4'h8, 3'h4, 4'h0, 3'h0, 2'h0, 1'b0);
    q(8'h00, 2'h0, 4'h4, 3'h0, 4'h0, 3'h0, 2'h0, 1'b0);
    q(8'h00, 2'h0, 4'h2, 3'h1, 4'h0, 3'h0, 2'h0, 1'b0);
    q(8'h10, 2'h0, 4'h2, 3'h0, 4'h0, 3'h0, 2'h0, 1'b0);
    q(8'h30, 2'h0, 4'h2, 3'h1, 4'h0, 3'h0, 2'h0, 1'b1);
    q(8'h20, 2'h0, 4'h6, 3'h1, 4'h0, 3'h0, 2'h0, 1'b1);
    q(8'h60, 2'h0, 4'hC, 3'h4, 4'h0, 3'h0, 2'h0, 1'b1);
    q(8'h40, 2'h0, 4'h9, 3'h0, 4'h0, 3'h0, 2'h0, 1'b1);
    q(8'h08, 2'h1, 4'h0, 3'h0, 4'h4, 3'h0, 2'h0, 1'b0);
    q(8'h01, 2'h1, 4'h0, 3'h0, 4'h1, 3'h0, 2'h0, 1'b1);
    q(8'h00, 2'h1, 4'h0, 3'h0, 4'h8, 3'h0, 2'h0, 1'b0);
    q(8'h02, 2'h2, 4'h0, 3'h0, 4'h0, 3'h2, 2'h0, 1'b1);
    q(8'h04, 2'h2, 4'h0, 3'h0, 4'h0, 3'h4, 2'h0, 1'b0);
    q(8'h02, 2'h3, 4'h0, 3'h0, 4'h0, 3'h0, 2'h1, 1'b0);
    q(8'h01, 2'h3, 4'h0, 3'h0, 4'h0, 3'h0, 2'h1, 1'b1);
    q(8'h08, 2'h2, 4'h0, 3'h0, 4'h8, 3'h1, 2'h0, 1'b0);
    // General counter wrap with its interrupt bit set
    kind = 4'h0;
    wreg(PQC_SEL_GPCTR_BASE, 64'hFF_FFFF_FFFF);
    wreg(PQC_SEL_EVSEL_BASE, 64'h53_003C);
    n_irq = i_pqc_event_source.irq_seen;
    {fovf_seen, govf_seen} = '0;
    i_pqc_event_source.burst(5'h08, 1, 3);
    chk("gp overflow", 64'h1, {62'h0, govf_seen});
    chk("gp irq", 64'(n_irq + 1), 64'(i_pqc_event_source.irq_seen));
    rreg(PQC_SEL_GPCTR_BASE, 64'h0, "gp wrapped");
    summarize();
  end
endmodule // perf_event_qualify_counters_tb
